// >>> hw/gpe_pkg.sv
package gpe_pkg;

   // Port width and configuration-space indices.
   localparam int PIN_CNT = 8;
   localparam logic [7:0] IDX_PIN_SELECT = 8'hF0;
   localparam logic [7:0] IDX_PIN_CONFIG_ONE = 8'hF1;
   localparam logic [7:0] IDX_PIN_EVENT_ROUTING = 8'hF2;
   localparam logic [7:0] IDX_PIN_CONFIG_TWO = 8'hF3;
   localparam logic [7:0] IDX_PORT_MODE_SELECT = 8'hF8;

   // Runtime register offsets on the runtime access port.
   localparam logic [2:0] RT_DATA_OUT_LATCH = 3'h0;
   localparam logic [2:0] RT_PIN_LEVEL_INPUT = 3'h1;
   localparam logic [2:0] RT_EVENT_ENABLE_MASK = 3'h2;
   localparam logic [2:0] RT_EVENT_STATUS_FLAGS = 3'h3;
   localparam logic [2:0] RT_COMBINED_DATA_IN_OUT = 3'h4;

   // Field positions in pin_config_one.
   localparam int CF1_OUT_ENABLE = 0;
   localparam int CF1_PUSH_PULL = 1;
   localparam int CF1_PULL_UP = 2;
   localparam int CF1_LOCK = 3;
   localparam int CF1_EVT_LEVEL = 4;
   localparam int CF1_EVT_POLARITY = 5;
   localparam int CF1_DEBOUNCE_EN = 6;
   localparam logic [7:0] CF1_WRITE_MASK = 8'h7F;
   localparam logic [7:0] CF1_LOCKED_MASK = 8'h0F;

   // Field positions in the other configuration registers.
   localparam int EVR_ROUTE_IRQ = 0;
   localparam int CF2_MAIN_POWERED_LOAD = 4;
   localparam int MODE_SEPARATE_DATA = 0;

   // Reset values.
   localparam logic [7:0] RST_PIN_SELECT = 8'h00;
   localparam logic [7:0] RST_PIN_CONFIG_ONE = 8'h40;
   localparam logic [7:0] RST_PIN_EVENT_ROUTING = 8'h01;
   localparam logic [7:0] RST_PIN_CONFIG_TWO = 8'h00;
   localparam logic [7:0] RST_PORT_MODE_SELECT = 8'h01;
   localparam logic [7:0] RST_DATA_OUT_LATCH = 8'hFF;
   localparam logic [7:0] RST_EVENT_ENABLE_MASK = 8'h00;
   localparam logic [7:0] RST_EVENT_STATUS_FLAGS = 8'h00;

   // Debounce timing: a least time, so the count rounds up.
   localparam longint CLK_HZ = 20_000_000;
   localparam longint DEBOUNCE_MS = 16;
   localparam int DEBOUNCE_CYCLES = int'((DEBOUNCE_MS * CLK_HZ + 999) / 1000);
   localparam int DEB_CNT_W = 19;

endpackage

// >>> hw/gpe_port.sv
`timescale 1ns/1ps

module gpe_port
   import gpe_pkg::*;
#(
   parameter int DEB_CYCLES = DEBOUNCE_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] pin_level_i,
   input wire logic block_active_i,
   input wire logic main_power_i,
   input wire logic [7:0] cfg_index_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_rdata_o,
   input wire logic [2:0] rt_addr_i,
   input wire logic rt_wr_i,
   input wire logic rt_rd_i,
   input wire logic [7:0] rt_wdata_i,
   output logic [7:0] rt_rdata_o,
   output logic [7:0] pin_out_o,
   output logic [7:0] pin_oe_o,
   output logic [7:0] pin_pullup_o,
   output logic irq_level_o,
   output logic irq_change_o,
   output logic power_mgmt_interrupt_o
);

   // Whole state of the port, registered in one place. The per-pin configuration
   // sits here as well, so a single reset branch covers every register and no
   // field can slip out of the reset by accident.
   typedef struct packed {
      logic [7:0] pin_select_index;
      logic [PIN_CNT-1:0][7:0] pin_config_one;
      logic [PIN_CNT-1:0][7:0] pin_event_routing;
      logic [PIN_CNT-1:0][7:0] pin_config_two;
      logic [7:0] port_mode_select;
      logic [7:0] data_out_latch;
      logic [7:0] event_enable_mask;
      logic [7:0] event_status_flags;
      logic [7:0] pin_meta;
      logic [7:0] pin_sync;
      logic [7:0] det_prev;
      logic [7:0] deb_level;
      logic [PIN_CNT-1:0][DEB_CNT_W-1:0] deb_cnt;
      logic pwr_meta;
      logic pwr_sync;
      logic [7:0] cfg_rdata;
      logic [7:0] rt_rdata;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [7:0] pin_pullup;
      logic irq_level;
      logic irq_change;
      logic pmi_level;
   } gpe_state_s;

   gpe_state_s state_ff;
   gpe_state_s nxt_state;

   localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEB_CYCLES - 1);

   // True when the detector sees the level selected by the polarity bit.
   function automatic logic level_is_active(input logic lvl, input logic polarity);
      level_is_active = (lvl == polarity);
   endfunction

   // Edge or level detection for one pin. An edge compares the detector input
   // with its value one cycle earlier.
   function automatic logic event_hit(input logic lvl, input logic prev,
                                      input logic [7:0] cfg);
      logic active;
      active = level_is_active(lvl, cfg[CF1_EVT_POLARITY]);
      if (cfg[CF1_EVT_LEVEL]) begin
         // A level source hits again every cycle while the pin stays active.
         event_hit = active;
      end else begin
         // Only the move into the active level counts as an edge.
         event_hit = (lvl != prev) & active;
      end
   endfunction

   // Write decode for the runtime event registers; both share the same gating,
   // so the enable and the status can never disagree about when access is open.
   function automatic logic event_reg_write(input logic wr, input logic open_ok,
                                            input logic sep_mode, input logic [2:0] addr,
                                            input logic [2:0] target);
      event_reg_write = wr & open_ok & sep_mode & (addr == target);
   endfunction

   // Output enable: push-pull always drives, open-drain only pulls low.
   // A pin wired to a main-powered load is never driven while that supply is gone.
   function automatic logic drive_enable(input logic [7:0] cfg, input logic dout,
                                         input logic dead);
      drive_enable = cfg[CF1_OUT_ENABLE] & ~dead & (cfg[CF1_PUSH_PULL] | ~dout);
   endfunction

   // New value of a pin's first configuration register on a write.
   // Bit 7 always reads zero; the lock keeps bits 3 to 0, itself included.
   function automatic logic [7:0] cfg_one_write(input logic [7:0] old,
                                                input logic [7:0] wd,
                                                input logic locked);
      if (locked) begin
         cfg_one_write = (old & CF1_LOCKED_MASK) | (wd & CF1_WRITE_MASK & ~CF1_LOCKED_MASK);
      end else begin
         cfg_one_write = wd & CF1_WRITE_MASK;
      end
   endfunction

   // Runtime read decode. Closed registers and unmapped offsets read zero, so a
   // host probing a switched-off port never sees stale event state.
   function automatic logic [7:0] rt_read_value(input logic [2:0] addr,
                                                input logic active,
                                                input logic open_ok,
                                                input logic [7:0] dout,
                                                input logic [7:0] din,
                                                input logic [7:0] enable,
                                                input logic [7:0] status);
      rt_read_value = 8'h00;
      if (active) begin
         unique case (addr)
            RT_DATA_OUT_LATCH: rt_read_value = dout;
            RT_PIN_LEVEL_INPUT: rt_read_value = din;
            RT_EVENT_ENABLE_MASK: rt_read_value = open_ok ? enable : 8'h00;
            RT_EVENT_STATUS_FLAGS: rt_read_value = open_ok ? status : 8'h00;
            RT_COMBINED_DATA_IN_OUT: rt_read_value = din;
            default: rt_read_value = 8'h00;
         endcase
      end
   endfunction

   // Configuration read decode; the per-pin registers show the selected pin only.
   // Unknown indices read zero so that probing the space has no side effect.
   function automatic logic [7:0] cfg_read_value(input logic [7:0] index,
                                                 input logic [7:0] select,
                                                 input logic [7:0] cfg_one,
                                                 input logic [7:0] routing,
                                                 input logic [7:0] cfg_two,
                                                 input logic [7:0] mode);
      unique case (index)
         IDX_PIN_SELECT: cfg_read_value = select;
         IDX_PIN_CONFIG_ONE: cfg_read_value = cfg_one;
         IDX_PIN_EVENT_ROUTING: cfg_read_value = routing;
         IDX_PIN_CONFIG_TWO: cfg_read_value = cfg_two;
         IDX_PORT_MODE_SELECT: cfg_read_value = mode;
         default: cfg_read_value = 8'h00;
      endcase
   endfunction

   // Next-state logic for the whole port.
   always_comb begin
      logic [2:0] sel;
      logic runtime_open;
      logic separate;
      logic [7:0] det_in;
      logic [7:0] hit;
      logic [7:0] pending;
      logic [7:0] load_off;
      logic [7:0] wr_clear;
      logic irq_any;
      logic pmi_any;
      logic lock_sel;
      sel = 3'h0;
      runtime_open = 1'b0;
      separate = 1'b0;
      det_in = 8'h00;
      hit = 8'h00;
      pending = 8'h00;
      load_off = 8'h00;
      wr_clear = 8'h00;
      irq_any = 1'b0;
      pmi_any = 1'b0;
      lock_sel = 1'b0;
      nxt_state = state_ff;

      // Pins and the supply sense come from outside the clock domain.
      // Only the second flop is read by logic, so a metastable first stage
      // never reaches the detector or the power gating.
      nxt_state.pin_meta = pin_level_i;
      nxt_state.pin_sync = state_ff.pin_meta;
      nxt_state.pwr_meta = main_power_i;
      nxt_state.pwr_sync = state_ff.pwr_meta;

      sel = state_ff.pin_select_index[2:0];
      separate = state_ff.port_mode_select[MODE_SEPARATE_DATA];
      // Runtime event registers are closed while inactive or unpowered.
      // Main power is judged from its synchronised copy, two cycles late.
      runtime_open = block_active_i & state_ff.pwr_sync;
      lock_sel = state_ff.pin_config_one[sel][CF1_LOCK];

      for (int i = 0; i < PIN_CNT; i++) begin
         // A pin feeding a main-powered load is dead while main power is off.
         load_off[i] = state_ff.pin_config_two[i][CF2_MAIN_POWERED_LOAD] &
                       ~state_ff.pwr_sync;

         // Debouncer: the level must hold with no transition for a full period.
         // A glitch shorter than the period restarts the count and never reaches
         // the detector; the cost is one counter per pin.
         if (state_ff.pin_sync[i] == state_ff.deb_level[i]) begin
            nxt_state.deb_cnt[i] = '0;
         end else if (state_ff.deb_cnt[i] == DEB_LAST) begin
            nxt_state.deb_level[i] = state_ff.pin_sync[i];
            nxt_state.deb_cnt[i] = '0;
         end else begin
            nxt_state.deb_cnt[i] = state_ff.deb_cnt[i] + 1'b1;
         end

         // The pending indication rises one debounce delay late; it falls on a status clear.
         // Level events take the same debounced input, so a held level is seen
         // one full period late whenever debounce is enabled.
         det_in[i] = state_ff.pin_config_one[i][CF1_DEBOUNCE_EN] ?
                     state_ff.deb_level[i] : state_ff.pin_sync[i];
         nxt_state.det_prev[i] = det_in[i];

         // Edge compares with the previous cycle; level is checked every cycle.
         hit[i] = event_hit(det_in[i], state_ff.det_prev[i],
                            state_ff.pin_config_one[i]);
         hit[i] = hit[i] & ~load_off[i];

         // Pin drivers: a zero always drives low, a one drives or releases.
         // The pin follows the latch one cycle late, which keeps every output
         // straight from a flop at the price of that single cycle.
         nxt_state.pin_out[i] = state_ff.data_out_latch[i];
         nxt_state.pin_oe[i] = drive_enable(state_ff.pin_config_one[i],
                                            state_ff.data_out_latch[i], load_off[i]);
         nxt_state.pin_pullup[i] = state_ff.pin_config_one[i][CF1_PULL_UP] & ~load_off[i];
      end

      // Status clear by writing ones, only in separate mode with access open.
      if (event_reg_write(rt_wr_i, runtime_open, separate, rt_addr_i,
                          RT_EVENT_STATUS_FLAGS)) begin
         wr_clear = rt_wdata_i;
      end
      // A new event in the clear cycle wins; main-load pins drop when unpowered.
      // Letting the clear win would lose an edge arriving in that same cycle,
      // and an edge is never seen a second time.
      nxt_state.event_status_flags = ((state_ff.event_status_flags & ~wr_clear) | hit) &
                                     ~load_off;

      // Event enable mask, writable only in separate mode with access open.
      // The mask never touches the status, which keeps recording events.
      if (event_reg_write(rt_wr_i, runtime_open, separate, rt_addr_i,
                          RT_EVENT_ENABLE_MASK)) begin
         nxt_state.event_enable_mask = rt_wdata_i;
      end

      // Data-out latch: per-pin lock protects the bit.
      // Only block activation gates these writes: the latch sits on standby
      // power and keeps driving the pins without a main-powered load while main power is off.
      if (rt_wr_i && block_active_i &&
          ((separate && rt_addr_i == RT_DATA_OUT_LATCH) ||
           rt_addr_i == RT_COMBINED_DATA_IN_OUT)) begin
         for (int i = 0; i < PIN_CNT; i++) begin
            if (!state_ff.pin_config_one[i][CF1_LOCK]) begin
               nxt_state.data_out_latch[i] = rt_wdata_i[i];
            end
         end
      end

      // Pending is masked status; each pin goes to the target its routing picks.
      // A pin feeds exactly one target, never both.
      pending = state_ff.event_status_flags & state_ff.event_enable_mask;
      for (int i = 0; i < PIN_CNT; i++) begin
         if (state_ff.pin_event_routing[i][EVR_ROUTE_IRQ]) begin
            irq_any = irq_any | pending[i];
         end else begin
            pmi_any = pmi_any | pending[i];
         end
      end
      // The interrupt is detached when the block is off or main power is gone.
      // The power-management target stays ungated: it lives on the standby side
      // and must still be able to wake the system with main power off.
      nxt_state.irq_level = irq_any & block_active_i & state_ff.pwr_sync;
      nxt_state.pmi_level = pmi_any;
      // Every change of the interrupt level is flagged for the serializer.
      // The pulse stands in the same cycle as the new level, so both are taken
      // at one edge.
      nxt_state.irq_change = nxt_state.irq_level ^ state_ff.irq_level;

      // Runtime reads; closed registers and unmapped offsets read zero.
      if (rt_rd_i) begin
         nxt_state.rt_rdata = rt_read_value(rt_addr_i, block_active_i, runtime_open,
                                            state_ff.data_out_latch, state_ff.pin_sync,
                                            state_ff.event_enable_mask,
                                            state_ff.event_status_flags);
      end

      // Configuration writes through the pin select index.
      if (cfg_wr_i) begin
         unique case (cfg_index_i)
            IDX_PIN_SELECT: nxt_state.pin_select_index = {5'h00, cfg_wdata_i[2:0]};
            IDX_PIN_CONFIG_ONE: begin
               // Lock freezes the output fields and itself until reset.
               nxt_state.pin_config_one[sel] =
                  cfg_one_write(state_ff.pin_config_one[sel], cfg_wdata_i, lock_sel);
            end
            IDX_PIN_EVENT_ROUTING: begin
               nxt_state.pin_event_routing[sel] = {7'h00, cfg_wdata_i[EVR_ROUTE_IRQ]};
            end
            IDX_PIN_CONFIG_TWO: begin
               if (!lock_sel) begin
                  nxt_state.pin_config_two[sel] =
                     {3'h0, cfg_wdata_i[CF2_MAIN_POWERED_LOAD], 4'h0};
               end
            end
            IDX_PORT_MODE_SELECT: begin
               nxt_state.port_mode_select = {7'h00, cfg_wdata_i[MODE_SEPARATE_DATA]};
            end
            default: begin
            end
         endcase
      end

      // Configuration reads; unknown indices read zero.
      if (cfg_rd_i) begin
         nxt_state.cfg_rdata = cfg_read_value(cfg_index_i, state_ff.pin_select_index,
                                              state_ff.pin_config_one[sel],
                                              state_ff.pin_event_routing[sel],
                                              state_ff.pin_config_two[sel],
                                              state_ff.port_mode_select);
      end
   end

   // State register; synchronous reset puts every field at a constant.
   // The reset is synchronous, so the clock must run while it is held; a few
   // cycles after release let the synchronisers fill with real pin levels.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_ff <= '0;
         state_ff.pin_select_index <= RST_PIN_SELECT;
         state_ff.pin_config_one <= {PIN_CNT{RST_PIN_CONFIG_ONE}};
         state_ff.pin_event_routing <= {PIN_CNT{RST_PIN_EVENT_ROUTING}};
         state_ff.pin_config_two <= {PIN_CNT{RST_PIN_CONFIG_TWO}};
         state_ff.port_mode_select <= RST_PORT_MODE_SELECT;
         state_ff.data_out_latch <= RST_DATA_OUT_LATCH;
         state_ff.event_enable_mask <= RST_EVENT_ENABLE_MASK;
         state_ff.event_status_flags <= RST_EVENT_STATUS_FLAGS;
         state_ff.pin_out <= RST_DATA_OUT_LATCH;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Every output is a field of the registered state.
   assign cfg_rdata_o = state_ff.cfg_rdata;
   assign rt_rdata_o = state_ff.rt_rdata;
   assign pin_out_o = state_ff.pin_out;
   assign pin_oe_o = state_ff.pin_oe;
   assign pin_pullup_o = state_ff.pin_pullup;
   assign irq_level_o = state_ff.irq_level;
   assign irq_change_o = state_ff.irq_change;
   assign power_mgmt_interrupt_o = state_ff.pmi_level;

endmodule

// >>> sim/gpe_port_props.sv
`timescale 1ns/1ps
// Port-level checks; power gating is judged only after the synchroniser settles.
module gpe_port_props
   import gpe_pkg::*;
#(
   parameter int DEB_CYCLES = 8
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic block_active_i,
   input wire logic main_power_i,
   input wire logic [7:0] cfg_index_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_rdata_o,
   input wire logic [2:0] rt_addr_i,
   input wire logic rt_rd_i,
   input wire logic [7:0] rt_rdata_o,
   input wire logic irq_level_o,
   input wire logic irq_change_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Main power absent for longer than the two-flop synchroniser needs.
   sequence s_power_gone;
      !main_power_i [*6];
   endsequence
   a_irq_blk_off: assert property (!block_active_i && $past(!block_active_i) |-> !irq_level_o)
      else $error("irq high while block inactive");
   a_irq_pwr_off: assert property (s_power_gone |-> !irq_level_o)
      else $error("irq high while main power off");
   a_pwr_hides_st: assert property (s_power_gone ##0 (rt_rd_i && rt_addr_i == 3'h3)
      |=> rt_rdata_o == 8'h00) else $error("status visible while power off");
   a_rt_off_zero: assert property (rt_rd_i && !block_active_i |=> rt_rdata_o == 8'h00)
      else $error("runtime read while inactive not zero");
   a_chg_follows: assert property ($changed(irq_level_o) |-> irq_change_o)
      else $error("irq change not reported");
   a_chg_only_edge: assert property (irq_change_o |-> $changed(irq_level_o))
      else $error("irq change pulse without change");
   a_cfg_rd_hold: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
      else $error("config read data moved without read");
   a_rt_rd_hold: assert property (!rt_rd_i |=> $stable(rt_rdata_o))
      else $error("runtime read data moved without read");
   a_sel_width: assert property (cfg_rd_i && cfg_index_i == IDX_PIN_SELECT
      |=> cfg_rdata_o[7:3] == 5'h00) else $error("pin select upper bits set");
   a_route_bits: assert property (cfg_rd_i && cfg_index_i == IDX_PIN_EVENT_ROUTING
      |=> cfg_rdata_o[7:1] == 7'h00) else $error("routing upper bits set");
   a_rt_unmapped: assert property (rt_rd_i && rt_addr_i > 3'h4 |=> rt_rdata_o == 8'h00)
      else $error("unmapped runtime offset not zero");
endmodule
bind gpe_port gpe_port_props #(.DEB_CYCLES(DEB_CYCLES)) gpe_port_props_inst (.mclk_i, .rst_n_i,
   .block_active_i, .main_power_i, .cfg_index_i, .cfg_rd_i, .cfg_rdata_o, .rt_addr_i, .rt_rd_i,
   .rt_rdata_o, .irq_level_o, .irq_change_o);

// >>> sim/gpe_serirq_model.sv
`timescale 1ns/1ps
// Host-side serializer: it only resends the slot when told of a change, so a
// missed change pulse leaves a stale slot that the bench can see.
module gpe_serirq_model (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic irq_level_i,
   input wire logic irq_change_i,
   output logic slot_o
);
   // Slot value is taken from the new level on each reported change.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) slot_o <= 1'b0;
      else if (irq_change_i) slot_o <= irq_level_i;
   end
endmodule

// >>> sim/gpe_port_tb_top.sv
`timescale 1ns/1ps
module gpe_port_tb_top;
   logic clk, rst_n, act, pwr, cw_s, cr_s, rw_s, rr_s, slot;
   logic [7:0] idx, wd, ext, crd, rrd, po, poe, pu;
   logic [2:0] ra;
   logic irq, chg, pmi;
   wire logic [7:0] pin_w;
   int error_cnt = 0;
   int checks_done = 0;
   // Pin wire: the port wins where it drives, the outside level elsewhere.
   assign pin_w = (poe & po) | (~poe & ext);
   gpe_port #(.DEB_CYCLES(8)) gpe_port_inst (.mclk_i(clk), .rst_n_i(rst_n), .pin_level_i(pin_w),
      .block_active_i(act), .main_power_i(pwr), .cfg_index_i(idx), .cfg_wr_i(cw_s),
      .cfg_rd_i(cr_s), .cfg_wdata_i(wd), .cfg_rdata_o(crd), .rt_addr_i(ra), .rt_wr_i(rw_s),
      .rt_rd_i(rr_s), .rt_wdata_i(wd), .rt_rdata_o(rrd), .pin_out_o(po), .pin_oe_o(poe),
      .pin_pullup_o(pu), .irq_level_o(irq), .irq_change_o(chg), .power_mgmt_interrupt_o(pmi));
   gpe_serirq_model gpe_serirq_model_inst (.mclk_i(clk), .rst_n_i(rst_n), .irq_level_i(irq),
      .irq_change_i(chg), .slot_o(slot));
   // Free-running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One access: strobe for one edge, then a spare cycle so strobes never
   // get two assignments in one time step across back-to-back calls.
   task acc(input bit rt, input bit wr, input logic [7:0] a, input logic [7:0] d, input string nm);
      idx = a;
      ra = a[2:0];
      wd = d;
      if (rt) {rw_s, rr_s} = {wr, !wr};
      else {cw_s, cr_s} = {wr, !wr};
      cyc(1);
      {rw_s, rr_s, cw_s, cr_s} = 4'h0;
      if (!wr) chk(nm, d, rt ? rrd : crd);
      cyc(1);
   endtask
   task cfw(input logic [7:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, a, d, "");
   endtask
   task cfr(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, 1'b0, a, e, $sformatf("cfg %h", a));
   endtask
   task rtw(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 1'b1, a, d, "");
   endtask
   task rtr(input logic [7:0] a, input logic [7:0] e);
      acc(1'b1, 1'b0, a, e, $sformatf("rt %h", a));
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // A hang is cut short well after the expected few hundred cycles.
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
   // Main sequence; inputs move at falling edges only.
   initial begin
      {cw_s, cr_s, rw_s, rr_s} = 4'h0;
      idx = 8'h00;
      wd = 8'h00;
      ra = 3'h0;
      ext = 8'h00;
      act = 1'b1;
      pwr = 1'b1;
      rst_n = 1'b0;
      cyc(5);
      rst_n = 1'b1;
      cyc(3);
      cfr(8'hF0, 8'h00); cfr(8'hF1, 8'h40); cfr(8'hF2, 8'h01);
      cfr(8'hF3, 8'h00); cfr(8'hF8, 8'h01); rtr(0, 8'hFF); rtr(2, 8'h00);
      rtr(3, 8'h00); rtr(5, 8'h00); cfr(8'hF9, 8'h00);
      // Configure pins 0, 1, 2 and 4 before any enable; pin4 starts low to avoid an edge.
      rtw(0, 8'hEF);
      cfw(8'hF0, 8'h01); cfw(8'hF1, 8'h30);
      cfw(8'hF0, 8'h02); cfw(8'hF1, 8'h60);
      cfw(8'hF0, 8'h04); cfw(8'hF1, 8'h23);
      cfw(8'hF0, 8'h00); cfw(8'hF1, 8'h20); cfw(8'hF3, 8'h10);
      cfr(8'hF1, 8'h20);
      rtr(3, 8'h00);
      ext[0] = 1'b1; cyc(8);
      rtr(3, 8'h01); chk("irq", 8'h00, {7'h00, irq});
      rtw(2, 8'h03); cyc(3); chk("irq", 8'h01, {7'h00, irq});
      chk("slot", 8'h01, {7'h00, slot});
      rtw(3, 8'h00); rtr(3, 8'h01);
      rtw(3, 8'h01); cyc(3); rtr(3, 8'h00); chk("irq", 8'h00, {7'h00, irq});
      ext[1] = 1'b1; cyc(8); rtw(3, 8'h02); rtr(3, 8'h02);
      ext[1] = 1'b0; cyc(4); rtw(3, 8'h02); rtr(3, 8'h00);
      cfw(8'hF2, 8'h00); cfw(8'hF1, 8'h00); ext[0] = 1'b0; cyc(8);
      rtr(3, 8'h01); chk("pmi", 8'h01, {7'h00, pmi});
      chk("irq", 8'h00, {7'h00, irq});
      cfw(8'hF2, 8'h01); cyc(3); chk("irq", 8'h01, {7'h00, irq});
      act = 1'b0; cyc(2); chk("irq", 8'h00, {7'h00, irq}); rtr(3, 8'h00);
      act = 1'b1; cyc(2);
      ext[2] = 1'b1; cyc(3); ext[2] = 1'b0; cyc(20); rtr(3, 8'h01);
      ext[2] = 1'b1; cyc(6); rtr(3, 8'h01); cyc(12); rtr(3, 8'h05);
      pwr = 1'b0; cyc(8); chk("irq", 8'h00, {7'h00, irq}); rtr(3, 8'h00);
      pwr = 1'b1; cyc(6); rtr(3, 8'h04);
      rtr(1, 8'h04); rtw(1, 8'hFF); rtr(0, 8'hEF);
      rtw(0, 8'hFF); cyc(8); rtr(1, 8'h14); rtr(3, 8'h14);
      cfw(8'hF0, 8'h04); cfw(8'hF1, 8'h2B); rtw(0, 8'h00); rtr(0, 8'h10);
      cfw(8'hF8, 8'h00); rtw(2, 8'hFF); rtr(2, 8'h03);
      rtw(4, 8'h01); rtr(0, 8'h11); cfw(8'hF8, 8'h01);
      cfw(8'hF0, 8'h01); cfw(8'hF1, 8'h34); chk("pullup", 8'h02, pu);
      tally_and_finish();
   end
endmodule
